// ---- core/sscr_pkg.sv ----
// Constants for the serial configuration register group and its sync controls.
// Assumes a 15-bit byte address space reached through a 4-wire serial port.
package sscr_pkg;
	// Frame layout: R/W flag, 15-bit address, then 8-bit data bytes
	localparam int unsigned HDR_BITS   = 16;
	localparam int unsigned BYTE_BITS  = 8;
	localparam logic [4:0]  HDR_LAST   = 5'h0F;
	localparam logic [4:0]  BYTE_LAST  = 5'h07;
	localparam int unsigned RW_BIT     = 15;

	// Byte addresses
	localparam logic [14:0] ADDR_CFG_A     = 15'h0000;
	localparam logic [14:0] ADDR_MAKER_LO  = 15'h000C;
	localparam logic [14:0] ADDR_MAKER_HI  = 15'h000D;
	localparam logic [14:0] ADDR_USER      = 15'h0010;
	localparam logic [14:0] ADDR_SYNC1     = 15'h0029;
	localparam logic [14:0] ADDR_SYNC2     = 15'h002A;
	localparam logic [14:0] ADDR_POS_B0    = 15'h002C;
	localparam logic [14:0] ADDR_POS_B1    = 15'h002D;
	localparam logic [14:0] ADDR_POS_B2    = 15'h002E;

	// Arbitrary value, not any real maker code
	localparam logic [15:0] MAKER_CODE     = 16'h5A3C;

	// Field positions
	localparam int unsigned CFG_SOFT_RST   = 7;
	localparam int unsigned CFG_ASCEND     = 5;
	localparam int unsigned CFG_SDO_ACT    = 4;
	localparam int unsigned USR_ADDR_HOLD  = 0;
	localparam int unsigned S1_PROC_EN     = 6;
	localparam int unsigned S1_RECV_EN     = 5;
	localparam int unsigned S1_FINE        = 4;
	localparam int unsigned S1_PICK_HI     = 3;
	localparam int unsigned S1_PICK_LO     = 0;
	localparam int unsigned S2_MARKER      = 3;
	localparam int unsigned S2_CLK_DC      = 2;
	localparam int unsigned S2_SYNC_DC     = 1;
	localparam int unsigned S2_FLIP        = 0;

	// Reset values and the config A read-only mask
	localparam logic [7:0]  CFG_A_RST      = 8'h20;
	localparam logic [7:0]  CFG_A_RO_MASK  = 8'h10;
	localparam logic [7:0]  USER_RST       = 8'h00;
	localparam logic [7:0]  SYNC1_RST      = 8'h00;
	localparam logic [7:0]  SYNC2_RST      = 8'h00;
endpackage

// ---- core/sscr_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for a group of pins.
// Assumes pins are asynchronous to core_clk and change slower than 3 cycles.
`timescale 1ns/1ps
module sscr_pin_sync #(
	parameter int unsigned W = 4
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] filt;
		logic [W-1:0] rise;
		logic [W-1:0] fall;
	} sscr_sync_state_type;

	sscr_sync_state_type state_ff;
	sscr_sync_state_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.s1 = pin_in;
		// First stage feeds only the second
		nxt_state.s2 = state_ff.s1;
		nxt_state.s3 = state_ff.s2;
		for (int i = 0; i < W; i++) begin
			// A change counts only once stages two and three agree
			if (state_ff.s2[i] == state_ff.s3[i]) begin
				nxt_state.filt[i] = state_ff.s3[i];
			end
		end
		nxt_state.rise = nxt_state.filt & ~state_ff.filt;
		nxt_state.fall = ~nxt_state.filt & state_ff.filt;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign level = state_ff.filt;
	assign rise  = state_ff.rise;
	assign fall  = state_ff.fall;
endmodule

// ---- core/sscr_regs.sv ----
// Serial configuration port with maker word, user config and sync controls.
// Assumes a 4-wire serial port (mode 0) far slower than core_clk.
//
// Contract
// - Read-only 16-bit maker word, writes ignored
// - Address freeze holds streaming address constant
// - Freeze clear: step address by direction
// - Direction 1 increments, 0 decrements per byte
// - Processor enable bit gates sync events
// - Receiver enable bit switches receiver on
// - Four-bit field picks capture delay
// - Report 24-bit read-only capture position
// - Marker bit plus output enable routes sync
// - Clock input DC mode bit
// - Sync input DC mode bit
// - Polarity flip inverts sync reference
// - User and sync control registers reset to zero; config A resets to 0x20
`timescale 1ns/1ps
module sscr_regs (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        spi_sclk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_sdi,
	output logic             spi_sdo,
	input  wire logic        sync_ref,
	input  wire logic        marker_output_enable,
	input  wire logic [23:0] capture_position_status,
	output logic             sync_receiver_enable,
	output logic             sync_processor_enable,
	output logic             window_fine_scale,
	output logic [3:0]       window_delay_pick,
	output logic             clock_input_dc_mode,
	output logic             sync_input_dc_mode,
	output logic             sync_event,
	output logic             sample_lsb_marker
);
	typedef struct packed {
		logic [7:0]  cfg_a;
		logic [7:0]  user_serial_cfg;
		logic [7:0]  sync_ctrl_first;
		logic [7:0]  sync_ctrl_second;
		logic [4:0]  cnt;
		logic        data_phase;
		logic        rd;
		logic [15:0] hdr;
		logic [7:0]  dsh;
		logic [7:0]  rsh;
		logic [14:0] addr;
		logic        sdo;
		logic        aligned_prev;
		logic        sync_event;
		logic        marker;
	} sscr_state_type;

	sscr_state_type state_ff;
	sscr_state_type nxt_state;

	logic [3:0] pin_level;
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_active;
	logic       cs_start;
	logic       sdi_lvl;
	logic       sref_lvl;

	// Chip select enters inverted so a cleared synchroniser reads as idle
	sscr_pin_sync #(.W(4)) u_pin_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   ({sync_ref, spi_sdi, ~spi_cs_n, spi_sclk}),
		.level    (pin_level),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	assign sclk_rise = pin_rise[0];
	assign sclk_fall = pin_fall[0];
	assign cs_active = pin_level[1];
	assign cs_start  = pin_rise[1];
	assign sdi_lvl   = pin_level[2];
	assign sref_lvl  = pin_level[3];

	function automatic logic [7:0] rd_byte(
		input logic [14:0] a,
		input logic [7:0]  cfg,
		input logic [7:0]  usr,
		input logic [7:0]  s1,
		input logic [7:0]  s2,
		input logic [23:0] pos
	);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			sscr_pkg::ADDR_CFG_A:    r = cfg | sscr_pkg::CFG_A_RO_MASK;
			sscr_pkg::ADDR_MAKER_LO: r = sscr_pkg::MAKER_CODE[7:0];
			sscr_pkg::ADDR_MAKER_HI: r = sscr_pkg::MAKER_CODE[15:8];
			sscr_pkg::ADDR_USER:     r = usr;
			sscr_pkg::ADDR_SYNC1:    r = s1;
			sscr_pkg::ADDR_SYNC2:    r = s2;
			sscr_pkg::ADDR_POS_B0:   r = pos[7:0];
			sscr_pkg::ADDR_POS_B1:   r = pos[15:8];
			sscr_pkg::ADDR_POS_B2:   r = pos[23:16];
			default:                 r = 8'h00;
		endcase
		return r;
	endfunction

	always_comb begin
		logic [14:0] step_addr;
		logic [14:0] hdr_addr;
		logic [7:0]  wbyte;
		logic        aligned;
		step_addr = state_ff.addr;
		hdr_addr  = {state_ff.hdr[13:0], sdi_lvl};
		wbyte     = {state_ff.dsh[6:0], sdi_lvl};
		aligned   = 1'b0;
		nxt_state = state_ff;

		if (state_ff.user_serial_cfg[sscr_pkg::USR_ADDR_HOLD]) begin
			step_addr = state_ff.addr;
		end else if (state_ff.cfg_a[sscr_pkg::CFG_ASCEND]) begin
			step_addr = 15'(state_ff.addr + 15'h0001);
		end else begin
			step_addr = 15'(state_ff.addr - 15'h0001);
		end

		if (cs_start) begin
			nxt_state.cnt        = 5'h00;
			nxt_state.data_phase = 1'b0;
		end

		if (cs_active && sclk_rise) begin
			nxt_state.cnt = 5'(state_ff.cnt + 5'h01);
			if (!state_ff.data_phase) begin
				nxt_state.hdr = {state_ff.hdr[14:0], sdi_lvl};
				if (state_ff.cnt == sscr_pkg::HDR_LAST) begin
					nxt_state.cnt        = 5'h00;
					nxt_state.data_phase = 1'b1;
					nxt_state.rd         = state_ff.hdr[sscr_pkg::RW_BIT - 1];
					nxt_state.addr       = hdr_addr;
					nxt_state.rsh        = rd_byte(hdr_addr, state_ff.cfg_a,
						state_ff.user_serial_cfg, state_ff.sync_ctrl_first,
						state_ff.sync_ctrl_second, capture_position_status);
				end
			end else begin
				nxt_state.dsh = wbyte;
				if (state_ff.cnt == sscr_pkg::BYTE_LAST) begin
					nxt_state.cnt  = 5'h00;
					nxt_state.addr = step_addr;
					// Read data for the next streamed byte is fetched at the step
					nxt_state.rsh  = rd_byte(step_addr, state_ff.cfg_a,
						state_ff.user_serial_cfg, state_ff.sync_ctrl_first,
						state_ff.sync_ctrl_second, capture_position_status);
					if (!state_ff.rd) begin
						// Maker word and position bytes have no write path
						unique case (state_ff.addr)
							sscr_pkg::ADDR_CFG_A: begin
								nxt_state.cfg_a = wbyte & ~sscr_pkg::CFG_A_RO_MASK;
							end
							sscr_pkg::ADDR_USER:  nxt_state.user_serial_cfg  = wbyte;
							sscr_pkg::ADDR_SYNC1: nxt_state.sync_ctrl_first  = wbyte;
							sscr_pkg::ADDR_SYNC2: nxt_state.sync_ctrl_second = wbyte;
							default: begin
							end
						endcase
						// Soft reset is self-clearing; it restores every default
						if (state_ff.addr == sscr_pkg::ADDR_CFG_A
							&& wbyte[sscr_pkg::CFG_SOFT_RST]) begin
							nxt_state.cfg_a            = sscr_pkg::CFG_A_RST;
							nxt_state.user_serial_cfg  = sscr_pkg::USER_RST;
							nxt_state.sync_ctrl_first  = sscr_pkg::SYNC1_RST;
							nxt_state.sync_ctrl_second = sscr_pkg::SYNC2_RST;
						end
					end
				end
			end
		end

		if (!cs_active) begin
			nxt_state.sdo = 1'b0;
		end else if (sclk_fall && state_ff.data_phase) begin
			nxt_state.sdo = state_ff.rsh[7];
			nxt_state.rsh = {state_ff.rsh[6:0], 1'b0};
		end

		// Receiver off means the pin is ignored entirely
		if (state_ff.sync_ctrl_first[sscr_pkg::S1_RECV_EN]) begin
			aligned = sref_lvl ^ state_ff.sync_ctrl_second[sscr_pkg::S2_FLIP];
		end
		nxt_state.aligned_prev = aligned;
		nxt_state.sync_event   = aligned & ~state_ff.aligned_prev
			& state_ff.sync_ctrl_first[sscr_pkg::S1_PROC_EN];
		nxt_state.marker = aligned & marker_output_enable
			& state_ff.sync_ctrl_second[sscr_pkg::S2_MARKER];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= '{cfg_a: sscr_pkg::CFG_A_RST, default: '0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign spi_sdo               = state_ff.sdo;
	assign sync_receiver_enable  = state_ff.sync_ctrl_first[sscr_pkg::S1_RECV_EN];
	assign sync_processor_enable = state_ff.sync_ctrl_first[sscr_pkg::S1_PROC_EN];
	assign window_fine_scale     = state_ff.sync_ctrl_first[sscr_pkg::S1_FINE];
	assign window_delay_pick     =
		state_ff.sync_ctrl_first[sscr_pkg::S1_PICK_HI:sscr_pkg::S1_PICK_LO];
	assign clock_input_dc_mode   = state_ff.sync_ctrl_second[sscr_pkg::S2_CLK_DC];
	assign sync_input_dc_mode    = state_ff.sync_ctrl_second[sscr_pkg::S2_SYNC_DC];
	assign sync_event            = state_ff.sync_event;
	assign sample_lsb_marker     = state_ff.marker;
endmodule

// ---- test/sscr_monitor.sv ----
// Port checker for the serial config register group.
// Assumes sscr_regs ports; bound below.
`timescale 1ns/1ps
module sscr_monitor (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       spi_cs_n,
	input wire logic       marker_output_enable,
	input wire logic       sync_receiver_enable,
	input wire logic       sync_processor_enable,
	input wire logic       window_fine_scale,
	input wire logic [3:0] window_delay_pick,
	input wire logic       clock_input_dc_mode,
	input wire logic       sync_input_dc_mode,
	input wire logic       sync_event,
	input wire logic       sample_lsb_marker
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Settings only change inside a frame
	sequence bus_idle;
		spi_cs_n [*8];
	endsequence
	sequence proc_off;
		!sync_processor_enable [*2];
	endsequence
	reset_clear_a: assert property ($fell(rst) |-> !(sync_receiver_enable | sync_processor_enable
		| window_fine_scale | (|window_delay_pick) | clock_input_dc_mode | sync_input_dc_mode))
		else $error("controls not cleared by reset");
	event_gate_a: assert property (proc_off |-> !sync_event)
		else $error("sync event while processor off");
	event_pulse_a: assert property (sync_event |=> !sync_event)
		else $error("sync event longer than one cycle");
	marker_gate_a: assert property (!marker_output_enable [*2] |-> !sample_lsb_marker)
		else $error("marker without output enable");
	marker_recv_a: assert property (!sync_receiver_enable [*2] |-> !sample_lsb_marker)
		else $error("marker with receiver off");
	pick_hold_a: assert property (bus_idle |=> $stable(window_delay_pick))
		else $error("delay pick moved outside frame");
	mode_hold_a: assert property (bus_idle |=> $stable({clock_input_dc_mode, sync_input_dc_mode}))
		else $error("input mode moved outside frame");
	enable_hold_a: assert property (bus_idle |=> $stable({window_fine_scale, sync_receiver_enable}))
		else $error("enables moved outside frame");
endmodule

bind sscr_regs sscr_monitor u_mon (.core_clk, .rst, .spi_cs_n, .marker_output_enable,
	.sync_receiver_enable, .sync_processor_enable, .window_fine_scale, .window_delay_pick,
	.clock_input_dc_mode, .sync_input_dc_mode, .sync_event, .sample_lsb_marker);

// ---- test/sscr_regs_bench.sv ----
// Self-checking bench for the serial config register group.
// Assumes sscr_pkg and sscr_regs; serial clock is bit-banged slowly.
`timescale 1ns/1ps
module sscr_regs_bench;
	logic        core_clk = 0, rst = 1, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0, spi_sdo;
	logic        sync_ref = 0, marker_output_enable = 0, sync_event, sample_lsb_marker;
	logic [23:0] capture_position_status = 24'hC3B2A1;
	logic        sync_receiver_enable, sync_processor_enable, window_fine_scale;
	logic        clock_input_dc_mode, sync_input_dc_mode;
	logic [3:0]  window_delay_pick;
	logic [8:0]  outs;
	logic [7:0]  d [4];
	int          miscompares = 0, cmp_count = 0;
	assign outs = {sync_receiver_enable, sync_processor_enable, window_fine_scale,
		window_delay_pick, clock_input_dc_mode, sync_input_dc_mode};
	sscr_regs uut (.core_clk, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .sync_ref,
		.marker_output_enable, .capture_position_status, .sync_receiver_enable,
		.sync_processor_enable, .window_fine_scale, .window_delay_pick, .clock_input_dc_mode,
		.sync_input_dc_mode, .sync_event, .sample_lsb_marker);
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Half period of 8 clocks leaves margin over the synchroniser delay
	task automatic xfer(input logic [15:0] h, input int n);
		logic [7:0] r;
		spi_cs_n = 0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			spi_sdi = (i < 16) ? h[15 - i] : d[(i - 16) / 8][7 - i % 8];
			wt(8);
			r = {r[6:0], spi_sdo};
			spi_sclk = 1;
			wt(8);
			spi_sclk = 0;
			if (i > 15 && i % 8 == 7) d[(i - 16) / 8] = r;
		end
		wt(8);
		spi_cs_n = 1;
		wt(8);
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] v);
		d[0] = v;
		xfer({1'b0, a}, 1);
	endtask
	task automatic rd(input logic [14:0] a, input int n);
		xfer({1'b1, a}, n);
	endtask
	task automatic sref(input logic v, input logic [23:0] n);
		logic [23:0] c;
		c = 0;
		sync_ref = v;
		repeat (20) begin
			wt(1);
			c = c + sync_event;
		end
		chk("events", n, c);
	endtask
	task automatic t_reset;
		chk("controls", 9'h000, outs);
		rd(sscr_pkg::ADDR_USER, 1);
		chk("user", 8'h00, d[0]);
		rd(sscr_pkg::ADDR_SYNC1, 2);
		chk("sync regs", 16'h0000, {d[1], d[0]});
		$display("t_reset done");
	endtask
	task automatic t_maker;
		wr(sscr_pkg::ADDR_MAKER_LO, 8'hFF);
		rd(sscr_pkg::ADDR_MAKER_LO, 2);
		chk("maker", sscr_pkg::MAKER_CODE, {d[1], d[0]});
		rd(sscr_pkg::ADDR_POS_B0, 3);
		chk("position", capture_position_status, {d[2], d[1], d[0]});
		$display("t_maker done");
	endtask
	task automatic t_cfg;
		wr(sscr_pkg::ADDR_SYNC1, 8'h3A);
		wr(sscr_pkg::ADDR_SYNC2, 8'h06);
		chk("controls", 9'h16B, outs);
		wr(sscr_pkg::ADDR_SYNC1, 8'h20);
		chk("pick", 4'h0, window_delay_pick);
		$display("t_cfg done");
	endtask
	task automatic t_stream;
		wr(sscr_pkg::ADDR_CFG_A, 8'h00);
		rd(sscr_pkg::ADDR_SYNC2, 2);
		chk("descend", 16'h0620, {d[0], d[1]});
		wr(sscr_pkg::ADDR_USER, 8'h01);
		rd(sscr_pkg::ADDR_MAKER_LO, 3);
		chk("hold", {3{sscr_pkg::MAKER_CODE[7:0]}}, {d[2], d[1], d[0]});
		wr(sscr_pkg::ADDR_CFG_A, 8'h80);
		chk("soft reset", 9'h000, outs);
		rd(sscr_pkg::ADDR_MAKER_LO, 2);
		chk("ascend", sscr_pkg::MAKER_CODE, {d[1], d[0]});
		$display("t_stream done");
	endtask
	task automatic t_events;
		wr(sscr_pkg::ADDR_SYNC1, 8'h20);
		wr(sscr_pkg::ADDR_SYNC1, 8'h60);
		sref(1, 1);
		sref(0, 0);
		marker_output_enable = 1;
		wr(sscr_pkg::ADDR_SYNC2, 8'h0F);
		chk("marker", 1, sample_lsb_marker);
		sref(1, 0);
		chk("marker", 0, sample_lsb_marker);
		sref(0, 1);
		wr(sscr_pkg::ADDR_SYNC1, 8'h20);
		sref(1, 0);
		sref(0, 0);
		chk("marker", 1, sample_lsb_marker);
		marker_output_enable = 0;
		wt(2);
		chk("marker", 0, sample_lsb_marker);
		marker_output_enable = 1;
		wt(2);
		wr(sscr_pkg::ADDR_SYNC1, 8'h00);
		chk("marker", 0, sample_lsb_marker);
		$display("t_events done");
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// About 8800 clocks expected; generous margin
	initial begin
		wt(40000);
		miscompares++;
		wrap_up;
	end
	initial begin
		wt(6);
		rst = 0;
		wt(4);
		t_reset;
		t_maker;
		t_cfg;
		t_stream;
		t_events;
		wrap_up;
	end
endmodule
